// file: hw/dso_pkg.sv
// dso_pkg: constants, register map and carrier type for the drive status outputs
// assumes one 200 MHz clock shared by the register bus and the drive quantities
package dso_pkg;
    localparam int NUM_OC = 5;
    localparam int NUM_OUT = 6;
    localparam int POL_W = 2;
    localparam int FSEL_W = 6;
    localparam int FRQ_W = 16;
    localparam int HRS_W = 20;
    localparam int TWS_W = 14;
    localparam int ADR_W = 5;
    // --------------------------------------------------------------
    // register byte offsets, write masks, fields and reset values
    // --------------------------------------------------------------
    localparam logic [ADR_W-1:0] OFS_CTRL = 5'h00;
    localparam logic [ADR_W-1:0] OFS_FSEL_A = 5'h04;
    localparam logic [ADR_W-1:0] OFS_FSEL_B = 5'h08;
    localparam logic [ADR_W-1:0] OFS_THR1 = 5'h0c;
    localparam logic [ADR_W-1:0] OFS_THR2 = 5'h10;
    localparam logic [ADR_W-1:0] OFS_FMAX = 5'h14;
    localparam logic [ADR_W-1:0] OFS_TWARN = 5'h18;
    localparam logic [ADR_W-1:0] OFS_STAT = 5'h1c;
    localparam logic [31:0] MSK_CTRL = 32'h0000_3fff;
    localparam logic [31:0] MSK_FSEL_A = 32'h00ff_ffff;
    localparam logic [31:0] MSK_FSEL_B = 32'h0000_0fff;
    localparam logic [31:0] MSK_THR = 32'hffff_ffff;
    localparam logic [31:0] MSK_FMAX = 32'h0000_ffff;
    localparam logic [31:0] MSK_TWARN = 32'h0001_3fff;
    localparam int ACW_LSB = 12;
    localparam int DEC_LSB = 16;
    localparam int TWR_BIT = 16;
    // relay polarity nc, relay function alarm, fmax 60.00 Hz
    localparam logic [31:0] RST_CTRL = 32'h0000_0400;
    localparam logic [31:0] RST_FSEL_B = 32'h0000_0140;
    localparam logic [31:0] RST_FMAX = 32'h0000_1770;
    // --------------------------------------------------------------
    // codes
    // --------------------------------------------------------------
    localparam logic [POL_W-1:0] POL_NO = 2'h0;
    localparam logic [POL_W-1:0] POL_NC = 2'h1;
    localparam logic [1:0] ACW_3 = 2'h1;
    localparam logic [1:0] ACW_4 = 2'h2;
    localparam logic [2:0] AC_N0 = 3'h0;
    localparam logic [2:0] AC_N3 = 3'h3;
    localparam logic [2:0] AC_N4 = 3'h4;
    localparam logic [FSEL_W-1:0] FN_RUN = 6'h00;
    localparam logic [FSEL_W-1:0] FN_FA1 = 6'h01;
    localparam logic [FSEL_W-1:0] FN_FA2 = 6'h02;
    localparam logic [FSEL_W-1:0] FN_ALARM = 6'h05;
    localparam logic [FSEL_W-1:0] FN_FA3 = 6'h06;
    localparam logic [FSEL_W-1:0] FN_RNT = 6'h0b;
    localparam logic [FSEL_W-1:0] FN_ONT = 6'h0c;
    localparam logic [FSEL_W-1:0] FN_FA4 = 6'h18;
    localparam logic [FSEL_W-1:0] FN_FA5 = 6'h19;
    localparam int EV_RUN = 0;
    localparam int EV_FA1 = 1;
    localparam int EV_FA2 = 2;
    localparam int EV_FA3 = 3;
    localparam int EV_FA4 = 4;
    localparam int EV_FA5 = 5;
    localparam int EV_ALM = 6;
    localparam int EV_RNT = 7;
    localparam int EV_ONT = 8;
    localparam int NUM_EV = 9;
    // 1 % and 2 % of max frequency; warning units in hours
    localparam logic [FRQ_W-1:0] PCT1_DIV = 16'h0064;
    localparam logic [FRQ_W-1:0] PCT2_DIV = 16'h0032;
    localparam logic [6:0] TW_UNIT_LO = 7'h0a;
    localparam logic [6:0] TW_UNIT_HI = 7'h64;

    // frequencies in 0.01 Hz, times in hours
    typedef struct packed {
        logic [FRQ_W-1:0] out_freq;
        logic [FRQ_W-1:0] cmd_freq;
        logic running;
        logic dc_brake;
        logic tripped;
        logic [3:0] fault_code;
        logic [HRS_W-1:0] run_hours;
        logic [HRS_W-1:0] power_hours;
    } dso_drive_t;
endpackage : dso_pkg

// file: hw/dso_status_out.sv
// dso_status_out: status output logic of a motor drive (five open-collector
// outputs, one changeover alarm relay), configured over Avalon-MM.
// assumes drive quantities arrive synchronous to I_REF_CLK.
`timescale 1ns/1ps
`default_nettype none
module dso_status_out (
    input wire logic I_REF_CLK, // 200 MHz clock
    input wire logic I_RST_N, // async reset, active low
    input wire logic [dso_pkg::ADR_W-1:0] I_AVS_ADDRESS, // byte address
    input wire logic I_AVS_READ, // read request
    input wire logic I_AVS_WRITE, // write request
    input wire logic [31:0] I_AVS_WRITEDATA, // write data
    output logic [31:0] O_AVS_READDATA, // read data
    output logic O_AVS_WAITREQUEST, // stall
    input wire dso_pkg::dso_drive_t I_DRIVE, // drive quantities
    output logic [dso_pkg::NUM_OC-1:0] O_OC_ON, // 1: transistor conducts
    output logic O_RELAY_PAIR_A, // 1: pair a closed
    output logic O_RELAY_PAIR_B // 1: pair b closed
);
    import dso_pkg::*;

    // ----------------------------------------------------------
    // reset release
    // ----------------------------------------------------------
    logic rst_s1, rst_n;
    always_ff @(posedge I_REF_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // ----------------------------------------------------------
    // register slave
    // ----------------------------------------------------------
    logic [31:0] ctrl, fsel_a, fsel_b, fmax_r, twarn;
    logic [31:0] thr [2];
    logic [31:0] next_ctrl, next_fsel_a, next_fsel_b, next_fmax, next_twarn, next_rdata;
    logic [31:0] next_thr [2];
    logic next_wait;
    logic [NUM_EV-1:0] ev;
    logic [NUM_OUT*FSEL_W-1:0] fsel_all;
    assign fsel_all = {fsel_b[11:0], fsel_a[23:0]};

    function automatic logic [31:0] rd_mux(input logic [ADR_W-1:0] a, input logic [31:0] st);
        case (a)
            OFS_CTRL: rd_mux = ctrl;
            OFS_FSEL_A: rd_mux = fsel_a;
            OFS_FSEL_B: rd_mux = fsel_b;
            OFS_THR1: rd_mux = thr[0];
            OFS_THR2: rd_mux = thr[1];
            OFS_FMAX: rd_mux = fmax_r;
            OFS_TWARN: rd_mux = twarn;
            OFS_STAT: rd_mux = st;
            default: rd_mux = 32'h0;
        endcase
    endfunction : rd_mux

    // one wait cycle per access; write lands at the accepting edge
    always_comb
    begin
        next_wait = 1'b1;
        next_rdata = O_AVS_READDATA;
        next_ctrl = ctrl;
        next_fsel_a = fsel_a;
        next_fsel_b = fsel_b;
        next_thr = thr;
        next_fmax = fmax_r;
        next_twarn = twarn;
        if ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST)
            next_wait = 1'b0;
        if (I_AVS_READ && O_AVS_WAITREQUEST)
            next_rdata = rd_mux(I_AVS_ADDRESS, {17'h0, O_RELAY_PAIR_A, O_OC_ON, ev});
        if (I_AVS_WRITE && !O_AVS_WAITREQUEST)
        begin
            case (I_AVS_ADDRESS)
                OFS_CTRL: next_ctrl = I_AVS_WRITEDATA & MSK_CTRL;
                OFS_FSEL_A: next_fsel_a = I_AVS_WRITEDATA & MSK_FSEL_A;
                OFS_FSEL_B: next_fsel_b = I_AVS_WRITEDATA & MSK_FSEL_B;
                OFS_THR1: next_thr[0] = I_AVS_WRITEDATA & MSK_THR;
                OFS_THR2: next_thr[1] = I_AVS_WRITEDATA & MSK_THR;
                OFS_FMAX: next_fmax = I_AVS_WRITEDATA & MSK_FMAX;
                OFS_TWARN: next_twarn = I_AVS_WRITEDATA & MSK_TWARN;
                default: next_wait = 1'b1;
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            O_AVS_WAITREQUEST <= 1'b1;
            O_AVS_READDATA <= 32'h0;
            ctrl <= RST_CTRL;
            fsel_a <= 32'h0;
            fsel_b <= RST_FSEL_B;
            thr <= '{32'h0, 32'h0};
            fmax_r <= RST_FMAX;
            twarn <= 32'h0;
        end
        else
        begin
            O_AVS_WAITREQUEST <= next_wait;
            O_AVS_READDATA <= next_rdata;
            ctrl <= next_ctrl;
            fsel_a <= next_fsel_a;
            fsel_b <= next_fsel_b;
            thr <= next_thr;
            fmax_r <= next_fmax;
            twarn <= next_twarn;
        end
    end

    // ----------------------------------------------------------
    // comparators
    // ----------------------------------------------------------
    logic [FRQ_W:0] f, cmd, fon, foff, prev_f, next_prev;
    logic [FRQ_W:0] acc [2];
    logic [FRQ_W:0] dec [2];
    logic fa1, next_fa1, fa1_hit, rise, fall, run_over, pow_over, next_run_over, next_pow_over;
    logic [1:0] exc, next_exc, rch, next_rch;
    logic [TWS_W-1:0] tw_set;
    logic [20:0] tw_lim;
    assign f = {1'b0, I_DRIVE.out_freq};
    assign cmd = {1'b0, I_DRIVE.cmd_freq};
    assign fon = {1'b0, fmax_r[FRQ_W-1:0] / PCT1_DIV};
    assign foff = {1'b0, fmax_r[FRQ_W-1:0] / PCT2_DIV};
    assign rise = f > prev_f;
    assign fall = f < prev_f;
    assign fa1_hit = (f + fon) >= cmd;
    assign tw_set = twarn[TWS_W-1:0];
    // range flag picks 100 h units, else 10 h
    assign tw_lim = {7'h0, tw_set} * {14'h0, twarn[TWR_BIT] ? TW_UNIT_HI : TW_UNIT_LO};
    for (genvar k = 0; k < 2; k++)
    begin : g_thr
        assign acc[k] = {1'b0, thr[k][FRQ_W-1:0]};
        assign dec[k] = {1'b0, thr[k][DEC_LSB +: FRQ_W]};
    end

    // hysteresis state lives in flops, moves only at edges of the band
    always_comb
    begin
        next_prev = f;
        next_fa1 = fa1;
        next_exc = exc;
        next_rch = rch;
        // on at target -1%, off below target -2%
        if (fa1_hit)
            next_fa1 = 1'b1;
        else if ((f + foff) < cmd)
            next_fa1 = 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            // exceeded: accel threshold sets, decel one clears
            if (acc[k] != '0 && (f + fon) >= acc[k])
                next_exc[k] = 1'b1;
            else if ((acc[k] == '0 && dec[k] == '0) ||
                     (f + foff) < ((dec[k] != '0) ? dec[k] : acc[k]))
                next_exc[k] = 1'b0;
            // reached: set near, drop past the band
            if (!rch[k])
            begin
                if ((rise && acc[k] != '0 && (f + fon) >= acc[k] && f <= acc[k] + foff) ||
                    (fall && dec[k] != '0 && f <= dec[k] + fon && (f + foff) >= dec[k]))
                    next_rch[k] = 1'b1;
            end
            else if ((rise && f > acc[k] + foff) || (fall && (f + foff) < dec[k]) ||
                     (acc[k] == '0 && dec[k] == '0))
                next_rch[k] = 1'b0;
        end
        // setting zero keeps both warnings off
        next_run_over = (tw_set != '0) && ({1'b0, I_DRIVE.run_hours} > tw_lim);
        next_pow_over = (tw_set != '0) && ({1'b0, I_DRIVE.power_hours} > tw_lim);
    end

    // ----------------------------------------------------------
    // output mapping
    // ----------------------------------------------------------
    // running holds through dc braking
    assign ev[EV_RUN] = I_DRIVE.running || I_DRIVE.dc_brake;
    assign ev[EV_FA1] = fa1;
    assign ev[EV_FA2] = exc[0];
    assign ev[EV_FA3] = rch[0];
    assign ev[EV_FA4] = exc[1];
    assign ev[EV_FA5] = rch[1];
    assign ev[EV_ALM] = I_DRIVE.tripped;
    assign ev[EV_RNT] = run_over;
    assign ev[EV_ONT] = pow_over;

    // unknown codes give an idle output
    function automatic logic pick(input logic [FSEL_W-1:0] c, input logic [NUM_EV-1:0] e);
        case (c)
            FN_RUN: pick = e[EV_RUN];
            FN_FA1: pick = e[EV_FA1];
            FN_FA2: pick = e[EV_FA2];
            FN_FA3: pick = e[EV_FA3];
            FN_FA4: pick = e[EV_FA4];
            FN_FA5: pick = e[EV_FA5];
            FN_ALARM: pick = e[EV_ALM];
            FN_RNT: pick = e[EV_RNT];
            FN_ONT: pick = e[EV_ONT];
            default: pick = 1'b0;
        endcase
    endfunction : pick

    logic [2:0] ac_n;
    logic [NUM_OUT-1:0] act;
    // alarm code takes over the lowest outputs
    assign ac_n = (ctrl[ACW_LSB +: 2] == ACW_3) ? AC_N3 :
                  (ctrl[ACW_LSB +: 2] == ACW_4) ? AC_N4 : AC_N0;
    for (genvar i = 0; i < NUM_OUT; i++)
    begin : g_out
        logic src;
        assign src = (i < 4 && 3'(i) < ac_n) ? I_DRIVE.fault_code[i % 4]
                                             : pick(fsel_all[FSEL_W*i +: FSEL_W], ev);
        // nc setting inverts the contact sense
        assign act[i] = src ^ (ctrl[POL_W*i +: POL_W] == POL_NC);
    end

    always_ff @(posedge I_REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_f <= '0;
            fa1 <= 1'b0;
            exc <= 2'h0;
            rch <= 2'h0;
            run_over <= 1'b0;
            pow_over <= 1'b0;
            O_OC_ON <= '0;
            O_RELAY_PAIR_A <= 1'b0;
            O_RELAY_PAIR_B <= 1'b1;
        end
        else
        begin
            prev_f <= next_prev;
            fa1 <= next_fa1;
            exc <= next_exc;
            rch <= next_rch;
            run_over <= next_run_over;
            pow_over <= next_pow_over;
            O_OC_ON <= act[NUM_OC-1:0];
            // changeover: pair b always opposite pair a
            O_RELAY_PAIR_A <= act[NUM_OUT-1];
            O_RELAY_PAIR_B <= ~act[NUM_OUT-1];
        end
    end

    // ----------------------------------------------------------
    // assertions
    // ----------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!rst_n);
    sequence s_req;
        (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
    endsequence
    sequence s_ac4;
        ac_n == AC_N4 && ctrl[7:0] == 8'h0 && $stable(I_DRIVE.fault_code);
    endsequence
    sequence s_relay_nc_err;
        fsel_b[11:6] == FN_ALARM && ctrl[11:10] == POL_NC && I_DRIVE.tripped;
    endsequence

    bus_wait_a: assert property (s_req |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
        else $error("waitrequest did not drop for exactly one cycle");
    ctrl_write_a: assert property (I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == OFS_CTRL
        |=> ctrl == ($past(I_AVS_WRITEDATA) & MSK_CTRL))
        else $error("control write not stored");
    relay_pair_a: assert property (O_RELAY_PAIR_A != O_RELAY_PAIR_B)
        else $error("relay pairs not complementary");
    relay_nc_a: assert property (s_relay_nc_err [*2] |-> !O_RELAY_PAIR_A)
        else $error("relay pair a closed on error");
    relay_no_a: assert property ((fsel_b[11:6] == FN_ALARM && ctrl[11:10] == POL_NO
        && I_DRIVE.tripped) [*2] |-> O_RELAY_PAIR_A)
        else $error("relay pair a open on error");
    run_dc_a: assert property ((fsel_a[5:0] == FN_RUN && ctrl[1:0] == POL_NO && ac_n == AC_N0
        && I_DRIVE.dc_brake) [*2] |-> O_OC_ON[0])
        else $error("running indication lost during dc braking");
    fa1_on_a: assert property ($rose(fa1) |-> $past(fa1_hit))
        else $error("constant speed arrival rose early");
    thr_off_a: assert property (thr[0] == 32'h0 |=> !exc[0] && !rch[0])
        else $error("disabled threshold still asserted");
    time_off_a: assert property (tw_set == '0 |=> !run_over && !pow_over)
        else $error("time warning active while disabled");
    run_time_a: assert property (tw_set != '0 && {1'b0, I_DRIVE.run_hours} > tw_lim
        |=> run_over)
        else $error("run time over not raised");
    acode_out_a: assert property (s_ac4 [*2] |-> O_OC_ON[3:0] == $past(I_DRIVE.fault_code))
        else $error("alarm code not on outputs");
endmodule : dso_status_out
`default_nettype wire

// file: sim/dso_field_model.sv
// dso_field_model: control equipment wired to the status outputs
// assumes pulled-up open-collector inputs and one lamp on each relay pair
`timescale 1ns/1ps
`default_nettype none
module dso_field_model (
    input wire logic [dso_pkg::NUM_OC-1:0] i_oc_on, // transistor conducts
    input wire logic i_pair_a, // relay pair a closed
    input wire logic i_pair_b, // relay pair b closed
    output logic [dso_pkg::NUM_OC-1:0] o_term_low, // terminal pulled low
    output logic o_alarm_lamp, // lamp wired on pair a
    output logic o_ok_lamp // lamp wired on pair b
);
    import dso_pkg::*;
    // pull-up takes the terminal high whenever the transistor lets go
    assign o_term_low = i_oc_on;
    assign o_alarm_lamp = i_pair_a;
    assign o_ok_lamp = i_pair_b;
endmodule : dso_field_model
`default_nettype wire

// file: sim/dso_status_out_test.sv
// dso_status_out_test: self-checking bench for the drive status outputs
// assumes one 200 MHz clock; the field model stands on the output pins
`timescale 1ns/1ps
`default_nettype none
module dso_status_out_test;
    import dso_pkg::*;
    typedef struct {logic [31:0] v; logic [31:0] m;} dso_note_t;
    localparam logic [15:0] FQ_TAB [12] = '{16'h0793, 16'h0794, 16'h0849, 16'h0b90,
        16'h0f78, 16'h1068, 16'h0fa0, 16'h0f27, 16'h0b41, 16'h0b3f, 16'h0802, 16'h0757};
    localparam logic [4:0] FX_TAB [12] = '{5'h00, 5'h06, 5'h02, 5'h03, 5'h1b, 5'h0b,
        5'h1b, 5'h03, 5'h03, 5'h02, 5'h06, 5'h00};
    logic clk, rst_n, rd, wr, wait_rq, pa, pb, snap, alamp, oklamp;
    logic [ADR_W-1:0] adr;
    logic [31:0] wdat, rdat;
    logic [NUM_OC-1:0] oc, tlow;
    logic [15:0] lf;
    dso_drive_t drv;
    dso_note_t notes[$];
    dso_note_t cur;
    int mismatches, tests_run;

    dso_status_out u_dso_status_out (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(adr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .O_AVS_READDATA(rdat),
        .O_AVS_WAITREQUEST(wait_rq), .I_DRIVE(drv), .O_OC_ON(oc), .O_RELAY_PAIR_A(pa),
        .O_RELAY_PAIR_B(pb));
    dso_field_model u_dso_field_model (.i_oc_on(oc), .i_pair_a(pa), .i_pair_b(pb),
        .o_term_low(tlow), .o_alarm_lamp(alamp), .o_ok_lamp(oklamp));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // --------------------------------------------------------------
    // watcher: oldest note against the accepted read or the snapshot
    // --------------------------------------------------------------
    always @(posedge clk)
    begin
        if ((rd === 1'b1 && wait_rq === 1'b0) || snap === 1'b1)
        begin
            cur = notes.pop_front();
            if (snap === 1'b1)
                check({25'h0, oklamp, alamp, tlow} & cur.m, cur.v & cur.m);
            else
                check(rdat & cur.m, cur.v & cur.m);
        end
    end

    // --------------------------------------------------------------
    // bus and stimulus tasks
    // --------------------------------------------------------------
    // request held until waitrequest is sampled low at a rising edge
    // no local limit: a stalled slave is caught by the watchdog
    task automatic bus(input logic we, input logic [ADR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= ~we;
        wr <= we;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (wait_rq !== 1'b0)
            @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic wreg(input logic [ADR_W-1:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wreg

    task automatic rreg(input logic [ADR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{e, m});
        bus(1'b0, a, 32'h0);
    endtask : rreg

    // settle past the flop and hysteresis stages, then snapshot the pins
    task automatic see(input logic [4:0] o, input logic a);
        repeat (4) @(posedge clk);
        notes.push_back('{{25'h0, ~a, a, o}, 32'h0000_007f});
        snap <= 1'b1;
        @(posedge clk);
        snap <= 1'b0;
    endtask : see

    task automatic done(input string name);
        $display("test %s done, mismatches so far %0d", name, mismatches);
    endtask : done

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    initial
    begin
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        adr = '0;
        wdat = '0;
        snap = 1'b0;
        drv = '0;
        lf = 16'h0015;
        mismatches = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // ----------------------------------------------------------
        // registers
        // ----------------------------------------------------------
        rreg(OFS_CTRL, RST_CTRL, 32'hffff_ffff);
        rreg(OFS_FSEL_B, RST_FSEL_B, 32'hffff_ffff);
        rreg(OFS_FMAX, RST_FMAX, 32'hffff_ffff);
        // zero command at standstill already counts as arrived
        rreg(OFS_STAT, 32'h0000_4002, 32'hffff_ffff);
        rreg(5'h02, 32'h0000_0000, 32'hffff_ffff);
        lf = lfsr_next(lf);
        wreg(OFS_THR2, {lf, ~lf});
        rreg(OFS_THR2, {lf, ~lf}, 32'hffff_ffff);
        wreg(OFS_CTRL, 32'hffff_ffff);
        rreg(OFS_CTRL, MSK_CTRL, 32'hffff_ffff);
        wreg(OFS_CTRL, 32'h0000_0400);
        done("registers");
        // ----------------------------------------------------------
        // running indication, polarity, relay
        // ----------------------------------------------------------
        @(posedge clk);
        drv.running <= 1'b1;
        see(5'h1f, 1'b1);
        wreg(OFS_CTRL, 32'h0000_0555);
        see(5'h00, 1'b1);
        @(posedge clk);
        drv.running <= 1'b0;
        drv.dc_brake <= 1'b1;
        see(5'h00, 1'b1);
        wreg(OFS_CTRL, 32'h0000_0400);
        see(5'h1f, 1'b1);
        @(posedge clk);
        drv.dc_brake <= 1'b0;
        drv.tripped <= 1'b1;
        see(5'h00, 1'b0);
        wreg(OFS_CTRL, 32'h0000_0000);
        see(5'h00, 1'b1);
        @(posedge clk);
        drv.tripped <= 1'b0;
        see(5'h00, 1'b0);
        wreg(OFS_CTRL, 32'h0000_0400);
        done("polarity");
        // ----------------------------------------------------------
        // frequency arrival: fmax 60.00 Hz gives on 60, off 120
        // ----------------------------------------------------------
        @(posedge clk);
        drv.cmd_freq <= 16'h0bb8;
        wreg(OFS_FSEL_A, 32'h0060_6081);
        wreg(OFS_FSEL_B, 32'h0000_0159);
        wreg(OFS_THR1, 32'h07d0_07d0);
        wreg(OFS_THR2, 32'h0fa0_0fa0);
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk);
            drv.out_freq <= FQ_TAB[i];
            see(FX_TAB[i], 1'b1);
        end
        @(posedge clk);
        drv.cmd_freq <= 16'h076c;
        see(5'h01, 1'b1);
        @(posedge clk);
        drv.cmd_freq <= 16'h0bb8;
        see(5'h00, 1'b1);
        wreg(OFS_THR1, 32'h0000_0000);
        @(posedge clk);
        drv.out_freq <= 16'h07d0;
        see(5'h00, 1'b1);
        done("arrival");
        // ----------------------------------------------------------
        // time warnings: 5 gives 50 h, with range flag 500 h
        // ----------------------------------------------------------
        wreg(OFS_FSEL_A, 32'h0000_030b);
        wreg(OFS_TWARN, 32'h0000_0005);
        @(posedge clk);
        drv.running <= 1'b1;
        drv.run_hours <= 20'h00032;
        drv.power_hours <= 20'h00033;
        see(5'h0e, 1'b1);
        @(posedge clk);
        drv.run_hours <= 20'h00033;
        see(5'h0f, 1'b1);
        wreg(OFS_TWARN, 32'h0001_0005);
        see(5'h0c, 1'b1);
        @(posedge clk);
        drv.run_hours <= 20'h001f5;
        drv.power_hours <= 20'h001f5;
        see(5'h0f, 1'b1);
        wreg(OFS_TWARN, 32'h0000_0000);
        see(5'h0c, 1'b1);
        done("time warning");
        // ----------------------------------------------------------
        // alarm code replaces the first three or four outputs
        // ----------------------------------------------------------
        for (int w = 1; w < 3; w++)
        begin
            lf = lfsr_next(lf);
            @(posedge clk);
            drv.fault_code <= lf[3:0];
            wreg(OFS_CTRL, 32'h0000_0400 | (w << ACW_LSB));
            see((w == 1) ? {2'b01, lf[2:0]} : {1'b0, lf[3:0]}, 1'b1);
        end
        done("alarm code");
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule : dso_status_out_test
`default_nettype wire
